// ===== bench/amfm_config_sva.sv
// Port checker for the AM/FM modulation settings controller.
// Assumes it is bound into amfm_config; one clock, async active-low reset.
`timescale 1ns/100ps
module amfm_config_sva
  import amfm_pkg::*;
(
  // Clock and reset
  input wire logic              mclk_i,
  input wire logic              reset_n_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0]       reg_wdata_i,
  input wire logic              reg_write_i,
  input wire logic              reg_read_i,
  input wire logic [31:0]       reg_rdata_o,
  // Datapath control
  input wire logic              am_active_o,
  input wire logic              fm_active_o,
  input wire logic              am_internal_active_o,
  input wire logic              am_sum_sources_o,
  input wire logic              ext_indicator_o,
  input wire logic              ext_input_enable_o,
  input wire logic [DEPTH_W-1:0] amplitude_depth_setting_o,
  input wire logic [31:0]       am_rate_o,
  input wire logic [31:0]       fm_rate_o,
  input wire logic [31:0]       peak_deviation_setting_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_am_on;
    reg_write_i && reg_addr_i == ADDR_AMPLITUDE_MODULATION_ENABLE && reg_wdata_i[0];
  endsequence
  sequence s_fm_on;
    reg_write_i && reg_addr_i == ADDR_FREQUENCY_MODULATION_ENABLE && reg_wdata_i[0];
  endsequence
  sequence s_rd_once;
    reg_read_i ##1 !reg_read_i;
  endsequence
  property p_ext_en; ext_input_enable_o == 1'b1; endproperty
  property p_one_mode; !(am_active_o && fm_active_o); endproperty
  property p_src;
    am_sum_sources_o == am_internal_active_o && ext_indicator_o == !am_internal_active_o;
  endproperty
  property p_src_ext;
    reg_write_i && reg_addr_i == ADDR_AM_SRC && reg_wdata_i[0] |=> ext_indicator_o;
  endproperty
  property p_depth; amplitude_depth_setting_o <= DEPTH_MAX; endproperty
  property p_rates;
    am_rate_o >= F_MIN && am_rate_o <= AM_RATE_MAX && fm_rate_o >= F_MIN
      && fm_rate_o <= FM_RATE_MAX;
  endproperty
  property p_dev; peak_deviation_setting_o >= F_MIN && peak_deviation_setting_o <= DEV_MAX; endproperty
  property p_am_clears_fm; s_am_on |=> !fm_active_o; endproperty
  property p_fm_clears_am; s_fm_on |=> !am_active_o; endproperty
  property p_am_off;
    reg_write_i && reg_addr_i == ADDR_AMPLITUDE_MODULATION_ENABLE && !reg_wdata_i[0] |=> !am_active_o;
  endproperty
  property p_rd_stands; s_rd_once |=> reg_rdata_o == 32'h0; endproperty
  a_ext_en: assert property (p_ext_en) else $error("ext input disabled");
  a_one_mode: assert property (p_one_mode) else $error("two modes on");
  a_src: assert property (p_src) else $error("source outputs disagree");
  a_src_ext: assert property (p_src_ext) else $error("indicator off");
  a_depth: assert property (p_depth) else $error("depth above max");
  a_rates: assert property (p_rates) else $error("rate out of range");
  a_dev: assert property (p_dev) else $error("deviation out of range");
  a_am_clears_fm: assert property (p_am_clears_fm) else $error("fm kept");
  a_fm_clears_am: assert property (p_fm_clears_am) else $error("am kept");
  a_am_off: assert property (p_am_off) else $error("am stays on");
  a_rd_stands: assert property (p_rd_stands) else $error("read data held");
endmodule : amfm_config_sva

// ===== bench/amfm_host_model.sv
// Remote host model: issues register writes and reads to the controller.
// Assumes the caller waits for each task; strobes last one cycle.
`timescale 1ns/100ps
module amfm_host_model
  import amfm_pkg::*;
(
  // Clock
  input  wire logic              mclk_i,
  // Register port toward the controller
  output logic      [ADDR_W-1:0] reg_addr_o,
  output logic      [31:0]       reg_wdata_o,
  output logic                   reg_write_o,
  output logic                   reg_read_o
);
  initial begin
    reg_addr_o  = '0;
    reg_wdata_o = '0;
    reg_write_o = 1'b0;
    reg_read_o  = 1'b0;
  end
  // Released lines show the inverse so stale values never pass
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_write_o <= 1'b1;
    @(posedge mclk_i);
    reg_write_o <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge mclk_i);
    reg_addr_o <= a;
    reg_read_o <= 1'b1;
    @(posedge mclk_i);
    reg_read_o <= 1'b0;
    reg_addr_o <= ~a;
  endtask : rd
endmodule : amfm_host_model

// ===== bench/tb_am_fm_modulation_config.sv
// Testbench for the AM/FM settings controller, driven by the host model.
// Assumes 100 MHz clock; read results checked from a queue of notes.
`timescale 1ns/100ps
module tb_am_fm_modulation_config;
  import amfm_pkg::*;
  logic mclk_i, reset_n_i, reg_write, reg_read, rd_seen, irq_o, ext_indicator_o;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_o, dv;
  logic [31:0] exp_q [$];
  logic [31:0] names [6];
  int mismatches, checks_done, seed;
  amfm_mod_shape_t am_shape, fm_shape;
  amfm_host_model host (.mclk_i(mclk_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_write_o(reg_write), .reg_read_o(reg_read));
  amfm_config DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_write_i(reg_write), .reg_read_i(reg_read),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .am_active_o(), .fm_active_o(),
    .am_internal_active_o(), .am_sum_sources_o(), .ext_indicator_o(ext_indicator_o),
    .ext_input_enable_o(), .amplitude_depth_setting_o(), .am_shape_o(am_shape), .am_rate_o(),
    .fm_shape_o(fm_shape), .fm_rate_o(), .peak_deviation_setting_o());
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask : rd
  task automatic conclude();
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // Read monitor
  // ----------------------------------------------------------------
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) rd_seen <= 1'b0;
    else rd_seen <= reg_read;
  end
  always @(negedge mclk_i) begin
    if (rd_seen === 1'b1) begin
      if (exp_q.size() > 0) check(reg_rdata_o, exp_q.pop_front());
      else check(reg_rdata_o, ~reg_rdata_o);
    end
  end
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    reset_n_i = 1'b0;
    seed = 35148;
    names = '{NAME_ROUND, NAME_TWO, NAME_TRI, NAME_RAMP, NAME_RAND, NAME_USER};
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rd(ADDR_AMPLITUDE_MODULATION_ENABLE, 32'h0);
    rd(ADDR_FREQUENCY_MODULATION_ENABLE, 32'h0);
    rd(ADDR_AM_SRC, 32'h424F5448);
    rd(ADDR_DEPTH, 32'h64);
    rd(ADDR_AM_RATE, 32'h2710);
    rd(ADDR_FM_RATE, 32'h3E8);
    rd(ADDR_DEV, 32'h2710);
    rd(ADDR_CAR_FREQ, 32'h186A0);
    rd(6'h3C, 32'h0);
    for (int i = 0; i < 6; i++) begin
      host.wr(ADDR_AM_SHAPE, i);
      rd(ADDR_AM_SHAPE, names[i]);
      check({29'h0, am_shape}, i);
      host.wr(ADDR_FM_SHAPE, i);
      rd(ADDR_FM_SHAPE, names[i]);
      check({29'h0, fm_shape}, i);
    end
    host.wr(ADDR_AM_SHAPE, 32'h6);
    rd(ADDR_AM_SHAPE, 32'h55534552);
    host.wr(ADDR_DEPTH, 32'hFFFFFFFF);
    rd(ADDR_DEPTH, 32'h78);
    repeat (8) begin
      dv = $random(seed);
      dv = dv % 32'hC8;
      host.wr(ADDR_DEPTH, dv);
      rd(ADDR_DEPTH, (dv > 32'h78) ? 32'h78 : dv);
    end
    host.wr(ADDR_AM_RATE, 32'h0);
    rd(ADDR_AM_RATE, 32'h1);
    host.wr(ADDR_AM_RATE, 32'hFFFFFFFF);
    rd(ADDR_AM_RATE, 32'h1E8480);
    host.wr(ADDR_FM_RATE, 32'hFFFFFFFF);
    rd(ADDR_FM_RATE, 32'hF4240);
    host.wr(ADDR_AM_SRC, 32'h1);
    rd(ADDR_AM_SRC, 32'h00455854);
    check({31'h0, ext_indicator_o}, 32'h1);
    host.wr(ADDR_AM_SRC, 32'h0);
    @(negedge mclk_i);
    check({31'h0, ext_indicator_o}, 32'h0);
    host.wr(ADDR_FREQUENCY_MODULATION_ENABLE, 32'h1);
    rd(ADDR_FREQUENCY_MODULATION_ENABLE, 32'h1);
    host.wr(ADDR_AMPLITUDE_MODULATION_ENABLE, 32'h1);
    rd(ADDR_FREQUENCY_MODULATION_ENABLE, 32'h0);
    rd(ADDR_AMPLITUDE_MODULATION_ENABLE, 32'h1);
    host.wr(ADDR_STATUS, 32'h3);
    host.wr(ADDR_CAR_SHAPE, 32'h4);
    host.wr(ADDR_CAR_SHAPE, 32'h5);
    rd(ADDR_STATUS, 32'h2);
    rd(ADDR_ERROR, 32'hFFFFFF23);
    host.wr(ADDR_FREQUENCY_MODULATION_ENABLE, 32'h1);
    host.wr(ADDR_STATUS, 32'h3);
    host.wr(ADDR_MASK, 32'h0);
    host.wr(ADDR_DEV, 32'h30D40);
    rd(ADDR_DEV, 32'h186A0);
    check({31'h0, irq_o}, 32'h0);
    host.wr(ADDR_MASK, 32'h1);
    @(negedge mclk_i);
    check({31'h0, irq_o}, 32'h1);
    rd(ADDR_ERROR, 32'hFFFFFF23);
    rd(ADDR_ERROR, 32'h0);
    host.wr(ADDR_STATUS, 32'h1);
    @(negedge mclk_i);
    check({31'h0, irq_o}, 32'h0);
    host.wr(ADDR_FREQUENCY_MODULATION_ENABLE, 32'h0);
    host.wr(ADDR_CAR_SHAPE, 32'h2);
    host.wr(ADDR_CAR_FREQ, 32'hFFFFFFFF);
    rd(ADDR_CAR_FREQ, 32'h989680);
    host.wr(ADDR_DEV, 32'hFFFFFFFF);
    rd(ADDR_DEV, 32'h989680);
    rd(ADDR_ERROR, 32'hFFFFFF23);
    host.wr(ADDR_CTRL, 32'h1);
    host.wr(ADDR_DEV, 32'hFFFFFFFF);
    rd(ADDR_ERROR, 32'h0);
    host.wr(ADDR_CAR_SHAPE, 32'h0);
    host.wr(ADDR_CAR_FREQ, 32'hFFFFFFFF);
    rd(ADDR_CAR_FREQ, 32'h59682F00);
    repeat (4) @(posedge mclk_i);
    conclude();
  end
endmodule : tb_am_fm_modulation_config
bind amfm_config amfm_config_sva u_sva (.mclk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i,
  .reg_write_i, .reg_read_i, .reg_rdata_o, .am_active_o, .fm_active_o, .am_internal_active_o,
  .am_sum_sources_o, .ext_indicator_o, .ext_input_enable_o, .amplitude_depth_setting_o, .am_rate_o,
  .fm_rate_o, .peak_deviation_setting_o);

// ===== design/amfm_config.sv
// AM/FM modulation settings controller: checks, clamps and holds settings.
// Assumes a register port master on mclk_i; one access strobe per cycle.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
module amfm_config
  import amfm_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_write_i,
  input  wire logic              reg_read_i,
  output logic      [31:0]       reg_rdata_o,
  // Interrupt
  output logic                   irq_o,
  // Modulation datapath control
  output logic                   am_active_o,
  output logic                   fm_active_o,
  output logic                   am_internal_active_o,
  output logic                   am_sum_sources_o,
  output logic                   ext_indicator_o,
  output logic                   ext_input_enable_o,
  output logic      [DEPTH_W-1:0] amplitude_depth_setting_o,
  output amfm_mod_shape_t        am_shape_o,
  output logic      [31:0]       am_rate_o,
  output amfm_mod_shape_t        fm_shape_o,
  output logic      [31:0]       fm_rate_o,
  output logic      [31:0]       peak_deviation_setting_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  function automatic logic [31:0] shape_name(input amfm_mod_shape_t s);
    unique case (s)
      ROUND_WAVE_SHAPE: shape_name = NAME_ROUND;
      TWO_LEVEL_SHAPE:  shape_name = NAME_TWO;
      TRIANGLE_SHAPE:   shape_name = NAME_TRI;
      RAMP_SHAPE:       shape_name = NAME_RAMP;
      RANDOM_SHAPE:     shape_name = NAME_RAND;
      USER_SHAPE:       shape_name = NAME_USER;
      default:          shape_name = 32'h00000000;
    endcase
  endfunction : shape_name

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                 panel_reg;
  logic                 am_en_reg;
  logic                 fm_en_reg;
  logic                 src_ext_reg;
  logic                 src_both_reg;
  logic                 ext_en_reg;
  logic [DEPTH_W-1:0]   depth_reg;
  amfm_mod_shape_t      am_shape_reg;
  logic [31:0]          am_rate_reg;
  amfm_mod_shape_t      fm_shape_reg;
  logic [31:0]          fm_rate_reg;
  logic [31:0]          dev_reg;
  logic [31:0]          car_freq_reg;
  amfm_car_shape_t      car_shape_reg;
  logic [ST_W-1:0]      status_reg;
  logic [ST_W-1:0]      mask_reg;
  logic [31:0]          error_reg;
  logic [31:0]          rdata_reg;
  logic                 irq_reg;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire wr_ctrl   = reg_write_i && (reg_addr_i == ADDR_CTRL);
  wire wr_am_st  = reg_write_i && (reg_addr_i == ADDR_AMPLITUDE_MODULATION_ENABLE);
  wire wr_fm_st  = reg_write_i && (reg_addr_i == ADDR_FREQUENCY_MODULATION_ENABLE);
  wire wr_src    = reg_write_i && (reg_addr_i == ADDR_AM_SRC);
  wire wr_depth  = reg_write_i && (reg_addr_i == ADDR_DEPTH);
  wire wr_am_shp = reg_write_i && (reg_addr_i == ADDR_AM_SHAPE);
  wire wr_am_rt  = reg_write_i && (reg_addr_i == ADDR_AM_RATE);
  wire wr_fm_shp = reg_write_i && (reg_addr_i == ADDR_FM_SHAPE);
  wire wr_fm_rt  = reg_write_i && (reg_addr_i == ADDR_FM_RATE);
  wire wr_dev    = reg_write_i && (reg_addr_i == ADDR_DEV);
  wire wr_car_f  = reg_write_i && (reg_addr_i == ADDR_CAR_FREQ);
  wire wr_car_s  = reg_write_i && (reg_addr_i == ADDR_CAR_SHAPE);
  wire wr_status = reg_write_i && (reg_addr_i == ADDR_STATUS);
  wire wr_mask   = reg_write_i && (reg_addr_i == ADDR_MASK);
  wire rd_error  = reg_read_i  && (reg_addr_i == ADDR_ERROR);

  wire remote    = !panel_reg;
  wire mod_shape_ok = (reg_wdata_i[2:0] <= 3'h5);

  // ----------------------------------------------------------------
  // Carrier checks
  // ----------------------------------------------------------------
  wire amfm_car_shape_t car_shape_req = amfm_car_shape_t'(reg_wdata_i[2:0]);
  wire car_is_bad = (car_shape_reg == CAR_RANDOM) || (car_shape_reg == CAR_DC);
  wire req_is_bad = (car_shape_req == CAR_RANDOM) || (car_shape_req == CAR_DC);
  wire car_code_ok = (reg_wdata_i[2:0] <= 3'h6);
  wire modulating  = am_en_reg || fm_en_reg;
  // Noise or dc carrier refused while any mode is on
  wire car_s_reject = wr_car_s && car_code_ok && req_is_bad && modulating;
  wire car_s_take   = wr_car_s && car_code_ok && !car_s_reject;

  wire tri_req = (car_shape_req == CAR_TRIANGLE) || (car_shape_req == CAR_RAMP);
  wire tri_cur = (car_shape_reg == CAR_TRIANGLE) || (car_shape_reg == CAR_RAMP);
  wire [31:0] car_max_req = tri_req ? CAR_TRI_MAX :
                            (car_shape_req == CAR_ARB) ? CAR_ARB_MAX : CAR_MAX;
  wire [31:0] car_max_cur = tri_cur ? CAR_TRI_MAX :
                            (car_shape_reg == CAR_ARB) ? CAR_ARB_MAX : CAR_MAX;
  wire [31:0] car_f_new   = clamp(reg_wdata_i, F_MIN, car_max_cur);
  wire [31:0] car_f_keep  = clamp(car_freq_reg, F_MIN, car_max_req);

  // ----------------------------------------------------------------
  // Deviation checks
  // ----------------------------------------------------------------
  wire [31:0] sum_max  = tri_cur ? SUM_TRI_MAX :
                         (car_shape_reg == CAR_ARB) ? SUM_ARB_MAX : SUM_MAX;
  wire [31:0] dev_room = sum_max - car_freq_reg;
  wire [31:0] dev_req  = clamp(reg_wdata_i, F_MIN, DEV_MAX);
  wire [31:0] dev_lim1 = (fm_en_reg && (dev_req > car_freq_reg)) ?
                         car_freq_reg : dev_req;
  wire [31:0] dev_fin  = (dev_lim1 > dev_room) ? dev_room : dev_lim1;
  wire dev_conflict = wr_dev && (dev_fin != dev_req) && remote;

  // ----------------------------------------------------------------
  // Enables
  // ----------------------------------------------------------------
  wire am_on_req  = wr_am_st && reg_wdata_i[0];
  wire fm_on_req  = wr_fm_st && reg_wdata_i[0];
  wire en_reject  = (am_on_req || fm_on_req) && car_is_bad;
  wire am_en_next = wr_am_st ? (reg_wdata_i[0] && !car_is_bad) :
                    (fm_on_req && !car_is_bad) ? 1'b0 : am_en_reg;
  wire fm_en_next = wr_fm_st ? (reg_wdata_i[0] && !car_is_bad) :
                    (am_on_req && !car_is_bad) ? 1'b0 : fm_en_reg;

  // ----------------------------------------------------------------
  // Events, status and interrupt
  // ----------------------------------------------------------------
  wire reject_ev = (car_s_reject || en_reject) && remote;
  wire [ST_W-1:0] events = {reject_ev, dev_conflict};
  // Set wins over a write-one clear, bit by bit
  wire [ST_W-1:0] status_next;
  for (genvar b = 0; b < ST_W; b = b + 1) begin : g_status
    assign status_next[b] = events[b] ||
                            (status_reg[b] && !(wr_status && reg_wdata_i[b]));
  end
  wire [ST_W-1:0] mask_next   = wr_mask ? reg_wdata_i[ST_W-1:0] : mask_reg;
  // A read clears the logged error unless a new one arrives in the same cycle
  wire [31:0] error_next = (dev_conflict || reject_ev) ? ERR_CONFLICT :
                           rd_error ? 32'h00000000 : error_reg;

  // ----------------------------------------------------------------
  // Read selection
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    unique case (reg_addr_i)
      ADDR_CTRL:      rd_mux = {31'h00000000, panel_reg};
      ADDR_AMPLITUDE_MODULATION_ENABLE:  rd_mux = {31'h00000000, am_en_reg};
      ADDR_FREQUENCY_MODULATION_ENABLE:  rd_mux = {31'h00000000, fm_en_reg};
      ADDR_AM_SRC:    rd_mux = src_ext_reg ? NAME_EXT : NAME_BOTH;
      ADDR_DEPTH:     rd_mux = {24'h000000, depth_reg};
      ADDR_AM_SHAPE:  rd_mux = shape_name(am_shape_reg);
      ADDR_AM_RATE:   rd_mux = am_rate_reg;
      ADDR_FM_SHAPE:  rd_mux = shape_name(fm_shape_reg);
      ADDR_FM_RATE:   rd_mux = fm_rate_reg;
      ADDR_DEV:       rd_mux = dev_reg;
      ADDR_CAR_FREQ:  rd_mux = car_freq_reg;
      ADDR_CAR_SHAPE: rd_mux = {29'h00000000, car_shape_reg};
      ADDR_STATUS:    rd_mux = {30'h00000000, status_reg};
      ADDR_MASK:      rd_mux = {30'h00000000, mask_reg};
      ADDR_ERROR:     rd_mux = error_reg;
      default:        rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Mode enables
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      am_en_reg <= 1'b0;
      fm_en_reg <= 1'b0;
    end else begin
      am_en_reg <= am_en_next;
      fm_en_reg <= fm_en_next;
    end
  end

  // ----------------------------------------------------------------
  // Panel origin and source selection
  // ----------------------------------------------------------------
  // The internal and summing flags share one flop so they never disagree
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      panel_reg    <= 1'b0;
      src_ext_reg  <= 1'b0;
      src_both_reg <= 1'b1;
      ext_en_reg   <= 1'b1;
    end else begin
      if (wr_ctrl) begin
        panel_reg <= reg_wdata_i[CTRL_PANEL_BIT];
      end
      if (wr_src) begin
        src_ext_reg  <= reg_wdata_i[0];
        src_both_reg <= !reg_wdata_i[0];
      end
      // Held in a flop so the output comes from a register; never cleared
      ext_en_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Next values of the clamped settings
  // ----------------------------------------------------------------
  wire [DEPTH_W-1:0] depth_next = (reg_wdata_i > {24'h000000, DEPTH_MAX}) ? DEPTH_MAX :
                                  reg_wdata_i[DEPTH_W-1:0];
  wire [31:0] am_rate_next  = clamp(reg_wdata_i, F_MIN, AM_RATE_MAX);
  wire [31:0] fm_rate_next  = clamp(reg_wdata_i, F_MIN, FM_RATE_MAX);
  // A shape change re-clamps the carrier against the new limit
  wire [31:0] car_freq_next = wr_car_f ? car_f_new : car_f_keep;

  // ----------------------------------------------------------------
  // AM setting registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      depth_reg    <= DEPTH_RST;
      am_shape_reg <= ROUND_WAVE_SHAPE;
      am_rate_reg  <= AM_RATE_RST;
    end else begin
      if (wr_depth) begin
        depth_reg <= depth_next;
      end
      if (wr_am_shp && mod_shape_ok) begin
        am_shape_reg <= amfm_mod_shape_t'(reg_wdata_i[2:0]);
      end
      if (wr_am_rt) begin
        am_rate_reg <= am_rate_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // FM setting registers
  // ----------------------------------------------------------------
  // Deviation limits are checked only when the deviation is written
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fm_shape_reg <= ROUND_WAVE_SHAPE;
      fm_rate_reg  <= FM_RATE_RST;
      dev_reg      <= DEV_RST;
    end else begin
      if (wr_fm_shp && mod_shape_ok) begin
        fm_shape_reg <= amfm_mod_shape_t'(reg_wdata_i[2:0]);
      end
      if (wr_fm_rt) begin
        fm_rate_reg <= fm_rate_next;
      end
      if (wr_dev) begin
        dev_reg <= dev_fin;
      end
    end
  end

  // ----------------------------------------------------------------
  // Carrier registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      car_freq_reg  <= CAR_RST;
      car_shape_reg <= CAR_ROUND;
    end else begin
      if (wr_car_f || car_s_take) begin
        car_freq_reg <= car_freq_next;
      end
      if (car_s_take) begin
        car_shape_reg <= car_shape_req;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, mask and error
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_reg <= {ST_W{1'b0}};
      mask_reg   <= {ST_W{1'b0}};
      error_reg  <= 32'h00000000;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      error_reg  <= error_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and read data
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      // Level interrupt follows its cause by one edge
      irq_reg   <= |(status_next & mask_next);
      // Read data stand for one cycle only, zero otherwise
      rdata_reg <= reg_read_i ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o          = rdata_reg;
  assign irq_o                = irq_reg;
  assign am_active_o          = am_en_reg;
  assign fm_active_o          = fm_en_reg;
  assign am_internal_active_o = src_both_reg;
  assign am_sum_sources_o     = src_both_reg;
  assign ext_indicator_o      = src_ext_reg;
  assign ext_input_enable_o   = ext_en_reg;
  assign amplitude_depth_setting_o           = depth_reg;
  assign am_shape_o           = am_shape_reg;
  assign am_rate_o            = am_rate_reg;
  assign fm_shape_o           = fm_shape_reg;
  assign fm_rate_o            = fm_rate_reg;
  assign peak_deviation_setting_o       = dev_reg;

endmodule : amfm_config

// ===== design/amfm_pkg.sv
// Package for the AM/FM modulation settings controller.
// Assumes byte addresses on a plain register port, 32-bit data words.
package amfm_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 6;
  localparam logic [5:0]  ADDR_CTRL      = 6'h00;
  localparam logic [5:0]  ADDR_AMPLITUDE_MODULATION_ENABLE  = 6'h04;
  localparam logic [5:0]  ADDR_FREQUENCY_MODULATION_ENABLE  = 6'h08;
  localparam logic [5:0]  ADDR_AM_SRC    = 6'h0C;
  localparam logic [5:0]  ADDR_DEPTH     = 6'h10;
  localparam logic [5:0]  ADDR_AM_SHAPE  = 6'h14;
  localparam logic [5:0]  ADDR_AM_RATE   = 6'h18;
  localparam logic [5:0]  ADDR_FM_SHAPE  = 6'h1C;
  localparam logic [5:0]  ADDR_FM_RATE   = 6'h20;
  localparam logic [5:0]  ADDR_DEV       = 6'h24;
  localparam logic [5:0]  ADDR_CAR_FREQ  = 6'h28;
  localparam logic [5:0]  ADDR_CAR_SHAPE = 6'h2C;
  localparam logic [5:0]  ADDR_STATUS    = 6'h30;
  localparam logic [5:0]  ADDR_MASK      = 6'h34;
  localparam logic [5:0]  ADDR_ERROR     = 6'h38;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int          CTRL_PANEL_BIT = 0;
  localparam int          ST_CONFLICT    = 0;
  localparam int          ST_REJECT      = 1;
  localparam int          ST_W           = 2;
  localparam int          DEPTH_W        = 8;

  // ----------------------------------------------------------------
  // Shapes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ROUND_WAVE_SHAPE, TWO_LEVEL_SHAPE, TRIANGLE_SHAPE,
    RAMP_SHAPE, RANDOM_SHAPE, USER_SHAPE
  } amfm_mod_shape_t;

  typedef enum logic [2:0] {
    CAR_ROUND, CAR_TWO_LEVEL, CAR_TRIANGLE, CAR_RAMP,
    CAR_RANDOM, CAR_DC, CAR_ARB
  } amfm_car_shape_t;

  // Abbreviated names, ASCII right aligned
  localparam logic [31:0] NAME_ROUND = 32'h0053494E;
  localparam logic [31:0] NAME_TWO  = 32'h00535155;
  localparam logic [31:0] NAME_TRI  = 32'h00545249;
  localparam logic [31:0] NAME_RAMP = 32'h52414D50;
  localparam logic [31:0] NAME_RAND = 32'h4E4F4953;
  localparam logic [31:0] NAME_USER = 32'h55534552;
  localparam logic [31:0] NAME_BOTH = 32'h424F5448;
  localparam logic [31:0] NAME_EXT  = 32'h00455854;

  // ----------------------------------------------------------------
  // Limits and defaults, frequencies in units of 10 mHz
  // ----------------------------------------------------------------
  localparam logic [7:0]  DEPTH_MIN     = 8'h00;
  localparam logic [7:0]  DEPTH_MAX     = 8'h78;
  localparam logic [7:0]  DEPTH_RST     = 8'h64;
  localparam logic [31:0] F_MIN         = 32'h00000001;
  localparam logic [31:0] AM_RATE_MAX   = 32'h001E8480;
  localparam logic [31:0] AM_RATE_RST   = 32'h00002710;
  localparam logic [31:0] FM_RATE_MAX   = 32'h000F4240;
  localparam logic [31:0] FM_RATE_RST   = 32'h000003E8;
  localparam logic [31:0] DEV_MAX       = 32'h2CB41780;
  localparam logic [31:0] DEV_RST       = 32'h00002710;
  localparam logic [31:0] CAR_MAX       = 32'h59682F00;
  localparam logic [31:0] CAR_TRI_MAX   = 32'h00989680;
  localparam logic [31:0] CAR_ARB_MAX   = 32'h1DCD6500;
  localparam logic [31:0] CAR_RST       = 32'h000186A0;
  localparam logic [31:0] SUM_MAX       = 32'h5A0122C0;
  localparam logic [31:0] SUM_TRI_MAX   = 32'h01312D00;
  localparam logic [31:0] SUM_ARB_MAX   = 32'h1E65FB80;
  localparam logic [31:0] ERR_CONFLICT  = 32'hFFFFFF23;

endpackage : amfm_pkg
